// >>> pssd_map.vh
// Constants for the front-panel switch and status display block.
// Assumes a 125 MHz system clock and a three-digit seven-segment display.
`ifndef PSSD_MAP_VH
`define PSSD_MAP_VH
`define PSSD_CLK_HZ 125000000
`define PSSD_BLINK_MS 250
`define PSSD_FRAME_MS 1000
`define PSSD_DEFAULT_ADDR 8'h01
`define PSSD_ROTARY_SRC 8'h00
`define PSSD_DIP_TEST 0
`define PSSD_DIP_AXA 1
`define PSSD_DIP_AXB 2
`define PSSD_DIP_AXC 3
`define PSSD_SEG_BLANK 7'h00
`define PSSD_SEG_DASH 7'h40
`define PSSD_SEG_O 7'h5C
`define PSSD_SEG_F 7'h71
`define PSSD_SEG_A 7'h77
`define PSSD_SEG_N 7'h54
`define PSSD_SEG_C 7'h39
`define PSSD_SEG_T 7'h78
`endif

// >>> pssd_hex_seg.v
// Hex nibble to seven-segment pattern, registered output.
// Segment order {g,f,e,d,c,b,a}, active high.
`default_nettype none
module pssd_hex_seg (
    // Clock
    input wire i_clk,
    input wire i_ce,
    // Nibble in, pattern out
    input wire [3:0] i_nibble,
    output reg [6:0] o_seg
);
    always @(posedge i_clk) begin
        if (i_ce) begin
            case (i_nibble)
                4'h0: o_seg <= 7'h3F;
                4'h1: o_seg <= 7'h06;
                4'h2: o_seg <= 7'h5B;
                4'h3: o_seg <= 7'h4F;
                4'h4: o_seg <= 7'h66;
                4'h5: o_seg <= 7'h6D;
                4'h6: o_seg <= 7'h7D;
                4'h7: o_seg <= 7'h07;
                4'h8: o_seg <= 7'h7F;
                4'h9: o_seg <= 7'h6F;
                4'hA: o_seg <= 7'h77;
                4'hB: o_seg <= 7'h7C;
                4'hC: o_seg <= 7'h39;
                4'hD: o_seg <= 7'h5E;
                4'hE: o_seg <= 7'h79;
                default: o_seg <= 7'h71;
            endcase
        end
    end
endmodule // pssd_hex_seg
`default_nettype wire

// >>> pssd_top.v
// Front-panel logic: switch capture, address select and status display.
// Assumes switches synchronous to i_clk; status inputs driven by the servo core.
`include "pssd_map.vh"
`default_nettype none
module pssd_top #(
    parameter integer BLINK_CYCLES = (`PSSD_CLK_HZ / 1000) * `PSSD_BLINK_MS,
    parameter integer FRAME_CYCLES = (`PSSD_CLK_HZ / 1000) * `PSSD_FRAME_MS,
    parameter integer STARTUP_FRAMES = 2
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    input wire i_ce,
    input wire i_soft_reset,
    // Operator switches
    input wire [3:0] i_addr_high_nibble_switch,
    input wire [3:0] i_addr_low_nibble_switch,
    input wire [3:0] i_config_dip_bank,
    // Configuration and internal status
    input wire [7:0] i_address_source_param,
    input wire [7:0] i_tool_address,
    input wire i_three_axis,
    input wire i_system_check_done,
    input wire i_net_connected,
    input wire [2:0] i_axis_ready,
    input wire [2:0] i_axis_servo_on,
    input wire [2:0] i_axis_alarm,
    input wire [11:0] i_alarm_code_a,
    input wire [11:0] i_alarm_code_b,
    input wire [11:0] i_alarm_code_c,
    // Mode outputs
    output reg o_factory_mode,
    output reg o_test_mode,
    output reg [2:0] o_axis_disabled,
    output reg o_operation_enable,
    output reg [7:0] o_address,
    output reg [7:0] o_rotary_address,
    // Display
    output wire [6:0] o_seg_digit0,
    output wire [6:0] o_seg_digit1,
    output wire [6:0] o_seg_digit2,
    output reg [2:0] o_dp
);
    ////////////////////////////////////////////////////////////////////////
    localparam [4:0] ST_START = 5'b00001;
    localparam [4:0] ST_NET = 5'b00010;
    localparam [4:0] ST_ALM = 5'b00100;
    localparam [4:0] ST_OFF = 5'b01000;
    localparam [4:0] ST_TEST = 5'b10000;

    reg [31:0] blink_cnt_q;
    reg [31:0] frame_cnt_q;
    reg blink_q;
    reg frame_tick_q;
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg [1:0] alm_idx_q;
    reg [1:0] alm_idx_d;
    reg [1:0] start_cnt_q;
    reg [3:0] dip_q;
    reg [11:0] code_sel;
    reg [2:0] alm_pending;
    reg [3:0] nib1;
    reg [3:0] nib2;
    reg [3:0] nib0;
    reg [6:0] fix0_d;
    reg [6:0] fix1_d;
    reg [6:0] fix2_d;
    reg use_hex0_d;
    reg use_hex12_d;
    reg [6:0] fix0_q;
    reg [6:0] fix1_q;
    reg [6:0] fix2_q;
    reg use_hex0_q;
    reg use_hex12_q;
    wire [6:0] hex0;
    wire [6:0] hex1;
    wire [6:0] hex2;
    wire capture = i_reset | i_soft_reset;

    ////////////////////////////////////////////////////////////////////////
    // Switch capture; reset is sync so sampling on the same edge is legal
    always @(posedge i_clk) begin
        if (i_ce && capture) begin
            dip_q <= i_config_dip_bank;
            o_factory_mode <= &i_config_dip_bank;
            o_test_mode <= i_config_dip_bank[`PSSD_DIP_TEST] & ~&i_config_dip_bank;
            o_axis_disabled <= {i_config_dip_bank[`PSSD_DIP_AXC],
                                i_config_dip_bank[`PSSD_DIP_AXB],
                                i_config_dip_bank[`PSSD_DIP_AXA]};
            o_rotary_address <= {i_addr_high_nibble_switch, i_addr_low_nibble_switch};
        end
    end

    // Address source may change at run time; the rotary byte itself is latched
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_address <= `PSSD_DEFAULT_ADDR;
            o_operation_enable <= 1'b0;
        end else if (i_ce) begin
            if (i_address_source_param == `PSSD_ROTARY_SRC)
                o_address <= o_rotary_address;
            else
                o_address <= i_tool_address;
            // Drop on the capture edge so a new factory setting never leaks a cycle
            o_operation_enable <= ~o_factory_mode & ~i_soft_reset
                                  & (state_q != ST_START);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescalers for blink and frame stepping
    always @(posedge i_clk) begin
        if (i_reset) begin
            blink_cnt_q <= 32'h0000_0000;
            frame_cnt_q <= 32'h0000_0000;
            blink_q <= 1'b0;
            frame_tick_q <= 1'b0;
        end else if (i_ce) begin
            frame_tick_q <= 1'b0;
            if (blink_cnt_q == BLINK_CYCLES - 1) begin
                blink_cnt_q <= 32'h0000_0000;
                blink_q <= ~blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
            end
            if (frame_cnt_q == FRAME_CYCLES - 1) begin
                frame_cnt_q <= 32'h0000_0000;
                frame_tick_q <= 1'b1;
            end else begin
                frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    always @* begin
        alm_pending = i_axis_alarm & ~o_axis_disabled;
        if (!i_three_axis)
            alm_pending[2] = 1'b0;
        state_d = state_q;
        alm_idx_d = alm_idx_q;
        case (state_q)
            ST_START: begin
                if (o_factory_mode)
                    state_d = ST_OFF;
                else if (i_system_check_done && start_cnt_q == STARTUP_FRAMES)
                    state_d = o_test_mode ? ST_TEST : ST_NET;
            end
            ST_NET: begin
                if (frame_tick_q && (|alm_pending)) begin
                    state_d = ST_ALM;
                    // Lowest axis first so B precedes C
                    alm_idx_d = alm_pending[0] ? 2'd0 : (alm_pending[1] ? 2'd1 : 2'd2);
                end
            end
            ST_ALM: begin
                if (frame_tick_q) begin
                    if (alm_idx_q == 2'd0 && (|alm_pending[2:1])) begin
                        alm_idx_d = alm_pending[1] ? 2'd1 : 2'd2;
                    end else if (alm_idx_q == 2'd1 && alm_pending[2]) begin
                        alm_idx_d = 2'd2;
                    end else begin
                        state_d = ST_NET;
                    end
                end
            end
            ST_OFF: state_d = ST_OFF;
            ST_TEST: state_d = ST_TEST;
            default: state_d = ST_START;
        endcase
        // Soft capture does not restart the sequencer, so lock from any frame
        if (o_factory_mode)
            state_d = ST_OFF;
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            state_q <= ST_START;
            alm_idx_q <= 2'd0;
            start_cnt_q <= 2'd0;
        end else if (i_ce) begin
            state_q <= state_d;
            alm_idx_q <= alm_idx_d;
            if (frame_tick_q && state_q == ST_START && start_cnt_q != STARTUP_FRAMES)
                start_cnt_q <= start_cnt_q + 2'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digit content
    always @* begin
        case (alm_idx_q)
            2'd0: code_sel = i_alarm_code_a;
            2'd1: code_sel = i_alarm_code_b;
            default: code_sel = i_alarm_code_c;
        endcase
        nib0 = 4'h0;
        nib1 = o_address[7:4];
        nib2 = o_address[3:0];
        fix0_d = `PSSD_SEG_BLANK;
        fix1_d = `PSSD_SEG_BLANK;
        fix2_d = `PSSD_SEG_BLANK;
        use_hex0_d = 1'b0;
        use_hex12_d = 1'b0;
        case (state_q)
            ST_START: begin
                fix0_d = `PSSD_SEG_DASH;
                fix1_d = start_cnt_q[0] ? `PSSD_SEG_DASH : `PSSD_SEG_BLANK;
                fix2_d = start_cnt_q[1] ? `PSSD_SEG_DASH : `PSSD_SEG_BLANK;
            end
            ST_NET: begin
                if (i_net_connected) begin
                    fix0_d = `PSSD_SEG_C;
                    use_hex12_d = 1'b1;
                end else begin
                    fix0_d = `PSSD_SEG_N;
                    fix1_d = `PSSD_SEG_C;
                end
            end
            ST_ALM: begin
                nib0 = code_sel[11:8];
                nib1 = code_sel[7:4];
                nib2 = code_sel[3:0];
                use_hex0_d = 1'b1;
                use_hex12_d = 1'b1;
            end
            ST_OFF: begin
                fix0_d = `PSSD_SEG_O;
                fix1_d = `PSSD_SEG_F;
                fix2_d = `PSSD_SEG_F;
            end
            ST_TEST: begin
                fix0_d = `PSSD_SEG_T;
                fix1_d = `PSSD_SEG_DASH;
                fix2_d = `PSSD_SEG_T;
            end
            default: fix0_d = `PSSD_SEG_DASH;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            fix0_q <= `PSSD_SEG_BLANK;
            fix1_q <= `PSSD_SEG_BLANK;
            fix2_q <= `PSSD_SEG_BLANK;
            use_hex0_q <= 1'b0;
            use_hex12_q <= 1'b0;
            o_dp <= 3'b000;
        end else if (i_ce) begin
            fix0_q <= fix0_d;
            fix1_q <= fix1_d;
            fix2_q <= fix2_d;
            use_hex0_q <= use_hex0_d;
            use_hex12_q <= use_hex12_d;
            // Decimal points only carry servo status in the network frame
            if (state_q == ST_NET && i_net_connected)
                o_dp <= (i_axis_ready & i_axis_servo_on) |
                        (i_axis_ready & ~i_axis_servo_on & {3{blink_q}});
            else
                o_dp <= 3'b000;
        end
    end

    // Hex decoders register too, so both paths align on the same edge
    pssd_hex_seg u_hex0 (.i_clk(i_clk), .i_ce(i_ce), .i_nibble(nib0), .o_seg(hex0));
    pssd_hex_seg u_hex1 (.i_clk(i_clk), .i_ce(i_ce), .i_nibble(nib1), .o_seg(hex1));
    pssd_hex_seg u_hex2 (.i_clk(i_clk), .i_ce(i_ce), .i_nibble(nib2), .o_seg(hex2));

    assign o_seg_digit0 = use_hex0_q ? hex0 : fix0_q;
    assign o_seg_digit1 = use_hex12_q ? hex1 : fix1_q;
    assign o_seg_digit2 = use_hex12_q ? hex2 : fix2_q;
endmodule // pssd_top
`default_nettype wire

// >>> pssd_chk.sv
// Checker for the front-panel block: capture, address select, display.
// Assumes one clock domain; bound to every pssd_top instance.
`include "pssd_map.vh"
`default_nettype none
module pssd_chk (
    // Clock and control
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_soft_reset,
    // Switches and status
    input wire logic [3:0] i_addr_high_nibble_switch,
    input wire logic [3:0] i_addr_low_nibble_switch,
    input wire logic [3:0] i_config_dip_bank,
    input wire logic [7:0] i_address_source_param,
    input wire logic [7:0] i_tool_address,
    input wire logic i_system_check_done,
    input wire logic [2:0] i_axis_ready,
    // Outputs watched
    input wire logic o_factory_mode,
    input wire logic o_test_mode,
    input wire logic [2:0] o_axis_disabled,
    input wire logic o_operation_enable,
    input wire logic [7:0] o_address,
    input wire logic [7:0] o_rotary_address,
    input wire logic [6:0] o_seg_digit0,
    input wire logic [6:0] o_seg_digit1,
    input wire logic [6:0] o_seg_digit2,
    input wire logic [2:0] o_dp
);
    wire logic cap;
    wire logic soft_cap;
    assign cap = i_ce & (i_reset | i_soft_reset);
    // Factory captures force test mode off whatever bit 0 says, so kept apart
    assign soft_cap = i_ce & i_soft_reset & (i_config_dip_bank != 4'hf);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////
    property p_fac_en; o_factory_mode |-> !o_operation_enable; endproperty
    a_fac_en: assert property (p_fac_en) else $error("enabled in factory mode");
    property p_fac_seg; o_factory_mode |-> ##[0:60] (o_seg_digit0 == `PSSD_SEG_O
        && o_seg_digit1 == `PSSD_SEG_F && o_seg_digit2 == `PSSD_SEG_F); endproperty
    a_fac_seg: assert property (p_fac_seg) else $error("factory glyph missing");
    property p_hold; !cap && !$past(cap) |=> $stable(o_test_mode) && $stable(o_axis_disabled)
        && $stable(o_rotary_address) && $stable(o_factory_mode); endproperty
    a_hold: assert property (p_hold) else $error("settings changed while running");
    property p_test; soft_cap |-> ##2 o_test_mode == $past(i_config_dip_bank[0], 2); endproperty
    a_test: assert property (p_test) else $error("test mode wrong");
    property p_axis;
        soft_cap |-> ##2 o_axis_disabled == $past(i_config_dip_bank[3:1], 2);
    endproperty
    a_axis: assert property (p_axis) else $error("axis disable wrong");
    property p_rot; soft_cap |-> ##2 o_rotary_address ==
        {$past(i_addr_high_nibble_switch, 2), $past(i_addr_low_nibble_switch, 2)}; endproperty
    a_rot: assert property (p_rot) else $error("rotary byte wrong");
    property p_addr; !$past(i_reset) |-> o_address == (($past(i_address_source_param) == 8'h00)
        ? $past(o_rotary_address) : $past(i_tool_address)); endproperty
    a_addr: assert property (p_addr) else $error("address source wrong");
    property p_dark; (o_dp & ~$past(i_axis_ready)) == 3'b000; endproperty
    a_dark: assert property (p_dark) else $error("point lit while not ready");
    property p_start; !$past(i_system_check_done) && !$past(i_system_check_done, 2)
        && !$past(i_system_check_done, 3) && $past(o_seg_digit0) != `PSSD_SEG_C
        |-> o_seg_digit0 != `PSSD_SEG_C; endproperty
    a_start: assert property (p_start) else $error("status before check done");
endmodule // pssd_chk
bind pssd_top pssd_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
    .i_soft_reset(i_soft_reset), .i_addr_high_nibble_switch(i_addr_high_nibble_switch),
    .i_addr_low_nibble_switch(i_addr_low_nibble_switch), .i_config_dip_bank(i_config_dip_bank),
    .i_address_source_param(i_address_source_param), .i_tool_address(i_tool_address),
    .i_system_check_done(i_system_check_done), .i_axis_ready(i_axis_ready),
    .o_factory_mode(o_factory_mode), .o_test_mode(o_test_mode),
    .o_axis_disabled(o_axis_disabled), .o_operation_enable(o_operation_enable),
    .o_address(o_address), .o_rotary_address(o_rotary_address), .o_seg_digit0(o_seg_digit0),
    .o_seg_digit1(o_seg_digit1), .o_seg_digit2(o_seg_digit2), .o_dp(o_dp));
`default_nettype wire

// >>> pssd_panel.sv
// Model of the operator switches on the front panel.
// Assumes the bench changes settings off the clock edge.
`default_nettype none
module pssd_panel (
    // Switch levels
    output logic [3:0] o_hi,
    output logic [3:0] o_lo,
    output logic [3:0] o_dip
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shipped state: address 01h, all DIP positions off
    initial begin
        o_hi = 4'h0;
        o_lo = 4'h1;
        o_dip = 4'h0;
    end
    task set_switches(input logic [3:0] h, input logic [3:0] l, input logic [3:0] d);
        o_hi = h;
        o_lo = l;
        o_dip = d;
    endtask
endmodule // pssd_panel
`default_nettype wire

// >>> test_pssd_top.sv
// Self-checking bench for the front-panel block.
// Assumes the panel model supplies switches; status inputs are driven here.
`include "pssd_map.vh"
`default_nettype none
module test_pssd_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, srst = 1'b0, done = 1'b0, net = 1'b0, three = 1'b0;
    logic [7:0] param = 8'h00, tool = 8'h00;
    logic [2:0] rdy = 3'b000, son = 3'b000, alm = 3'b000;
    logic [11:0] ca = 12'h000, cb = 12'h000, cc = 12'h000;
    logic fm, tm, oen, seen_b, seen_c;
    logic [2:0] axd, dp;
    logic [7:0] addr, raddr;
    logic [6:0] d0, d1, d2, prev;
    logic [3:0] hi, lo, dip;
    logic [1:0] blink;
    int bad_count = 0, samples_checked = 0;
    logic [6:0] seg [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
    always #4 clk = ~clk;
    pssd_panel u_panel (.o_hi(hi), .o_lo(lo), .o_dip(dip));
    // Short counts keep startup and blink within a few dozen cycles
    pssd_top #(.BLINK_CYCLES(4), .FRAME_CYCLES(16), .STARTUP_FRAMES(2)) dut (.i_clk(clk),
        .i_reset(rst), .i_ce(1'b1), .i_soft_reset(srst), .i_addr_high_nibble_switch(hi),
        .i_addr_low_nibble_switch(lo), .i_config_dip_bank(dip), .i_address_source_param(param),
        .i_tool_address(tool), .i_three_axis(three), .i_system_check_done(done),
        .i_net_connected(net), .i_axis_ready(rdy), .i_axis_servo_on(son), .i_axis_alarm(alm),
        .i_alarm_code_a(ca), .i_alarm_code_b(cb), .i_alarm_code_c(cc), .o_factory_mode(fm),
        .o_test_mode(tm), .o_axis_disabled(axd), .o_operation_enable(oen), .o_address(addr),
        .o_rotary_address(raddr), .o_seg_digit0(d0), .o_seg_digit1(d1), .o_seg_digit2(d2),
        .o_dp(dp));
    ////////////////////////////////////////
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task conclude;
        $display("checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wait_d0(input logic [6:0] g);
        int n;
        for (n = 0; n < 200 && d0 !== g; n++) tick(1);
        if (d0 !== g) begin
            check(d0, g);
            conclude();
        end
    endtask
    task recapture(input logic [3:0] h, input logic [3:0] l, input logic [3:0] d);
        u_panel.set_switches(h, l, d);
        tick(4);
        srst = 1'b1;
        tick(1);
        srst = 1'b0;
        tick(3);
    endtask
    ////////////////////////////////////////
    initial begin
        tick(5);
        rst = 1'b0;
        tick(3);
        check(raddr, 8'h01);
        check(addr, 8'h01);
        tick(60);
        check(d0, `PSSD_SEG_DASH);
        done = 1'b1;
        net = 1'b1;
        wait_d0(`PSSD_SEG_C);
        tick(2);
        check({d1, d2}, {seg[0], seg[1]});
        $display("startup done");
        // Switches moved while running must not take effect yet
        u_panel.set_switches(4'h3, 4'h5, 4'b1011);
        tick(4);
        check({tm, axd, raddr}, {1'b0, 3'b000, 8'h01});
        recapture(4'h3, 4'h5, 4'b1011);
        check(tm, 1'b1);
        check(axd, 3'b101);
        check(raddr, 8'h35);
        recapture(4'h3, 4'h5, 4'h0);
        check(addr, 8'h35);
        wait_d0(`PSSD_SEG_C);
        tick(2);
        check({d1, d2}, {seg[3], seg[5]});
        param = 8'h01;
        tool = 8'h12;
        tick(2);
        check(addr, 8'h12);
        tick(20);
        check({d1, d2}, {seg[1], seg[2]});
        $display("address done");
        rdy = 3'b011;
        son = 3'b001;
        tick(4);
        blink = 2'b00;
        for (int i = 0; i < 20; i++) begin
            check({dp[2], dp[0]}, 2'b01);
            blink = blink | {dp[1], ~dp[1]};
            tick(1);
        end
        check(blink, 2'b11);
        $display("servo points done");
        three = 1'b1;
        cb = 12'h123;
        cc = 12'h345;
        alm = 3'b110;
        seen_b = 1'b0;
        seen_c = 1'b0;
        prev = d0;
        for (int i = 0; i < 200 && !seen_c; i++) begin
            if ({d0, d1, d2} === {seg[1], seg[2], seg[3]} && !seen_b) begin
                check(prev, `PSSD_SEG_C);
                seen_b = 1'b1;
            end
            if ({d0, d1, d2} === {seg[3], seg[4], seg[5]}) begin
                check(seen_b, 1'b1);
                seen_c = 1'b1;
            end
            prev = d0;
            tick(1);
        end
        check(seen_c, 1'b1);
        $display("alarm done");
        alm = 3'b000;
        recapture(4'h0, 4'h1, 4'hf);
        check({fm, oen, tm}, 3'b100);
        wait_d0(`PSSD_SEG_O);
        check({d1, d2}, {`PSSD_SEG_F, `PSSD_SEG_F});
        $display("factory done");
        // Second reset mid-run with the test position on
        u_panel.set_switches(4'h0, 4'h1, 4'h1);
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        tick(2);
        check({fm, tm, oen}, 3'b010);
        wait_d0(`PSSD_SEG_T);
        check({d1, d2}, {`PSSD_SEG_DASH, `PSSD_SEG_T});
        check(oen, 1'b1);
        $display("test mode done");
        conclude();
    end
endmodule // test_pssd_top
`default_nettype wire
